// ===== logic_compare_unit.sv
// Functional notes
// RQ1 - AND with an immediate writes the working register and changes only zero.
// RQ2 - AND with a memory byte writes the register or the byte and changes only zero.
// RQ3 - OR with an immediate writes the working register and changes only zero.
// RQ4 - OR with a memory byte writes the register or the byte and changes only zero.
// RQ5 - XOR with an immediate writes the working register and changes only zero.
// RQ6 - XOR with a memory byte writes the register or the byte and changes only zero.
// RQ7 - XOR with the port A data register writes the working register and changes only zero.
// RQ8 - XOR into the port A data register writes that register and changes no flag.
// RQ9 - Inverting the working register changes only zero.
// RQ10 - Inverting a memory byte in place changes only zero.
// RQ11 - Negating the working register changes only zero.
// RQ12 - Negating a memory byte in place changes only zero.
// RQ13 - Immediate compare sets all four flags from register minus immediate, storing nothing.
// RQ14 - Memory compare sets all four flags from register minus byte, storing nothing.
// RQ15 - Reversed compare sets all four flags from byte minus register, storing nothing.
// RQ16 - Compare carry means borrow, zero means equal, both clear when the first is larger.
// RQ17 - Zero is set exactly when the affected result or difference is zero.
`timescale 1ns/1ps
`default_nettype none

module logic_compare_unit (
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  // Operation request.
  input wire logic start_i,
  input wire logic_compare_pkg::op_t op_i,
  input wire logic [logic_compare_pkg::DATA_W-1:0] imm_i,
  input wire logic [logic_compare_pkg::ADDR_W-1:0] addr_i,
  input wire logic to_mem_i,
  // Status.
  output logic busy_o,
  output logic done_o,
  // Architectural state.
  output logic [logic_compare_pkg::DATA_W-1:0] working_register_o,
  output logic [logic_compare_pkg::DATA_W-1:0] port_a_data_o,
  output logic zero_flag_o,
  output logic carry_flag_o,
  output logic nibble_borrow_flag_o,
  output logic signed_range_flag_o
);
  import logic_compare_pkg::*;

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Returns {range, nibble, carry, zero} for a minus b.
  function automatic logic [3:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] diff;
    logic [4:0] low;
    logic ovf;
    diff = {1'b0, a} - {1'b0, b};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    ovf = (a[7] ^ b[7]) & (a[7] ^ diff[7]);
    return {ovf, low[4], diff[8], (diff[7:0] == 8'h00)};
  endfunction

  function automatic logic is_mem_read(input op_t op);
    return (op == OP_AND_MEM) || (op == OP_OR_MEM) || (op == OP_XOR_MEM) ||
           (op == OP_NOT_MEM) || (op == OP_NEG_MEM) || (op == OP_CMP_MEM) ||
           (op == OP_CMP_REV);
  endfunction

  // ***********************************************************
  // State
  // ***********************************************************
  state_t state_reg, state_next;
  op_t op_reg, op_next;
  logic [7:0] imm_reg, imm_next;
  logic [7:0] addr_reg, addr_next;
  logic to_mem_reg, to_mem_next;
  logic [7:0] wr_reg, wr_next;
  logic [7:0] pa_reg, pa_next;
  logic [3:0] flags_reg, flags_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  data_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .clk_en_i(clk_en_i),
    .wr_en_i(mem_we),
    .wr_addr_i(addr_reg),
    .wr_data_i(mem_wdata),
    .rd_addr_i(addr_reg),
    .rd_data_o(mem_rdata)
  );

  // ***********************************************************
  // Execute
  // ***********************************************************
  always_comb begin
    logic [7:0] opnd;
    logic [7:0] res;
    logic [3:0] cf;
    opnd = 8'h00;
    res = 8'h00;
    cf = 4'h0;
    state_next = state_reg;
    op_next = op_reg;
    imm_next = imm_reg;
    addr_next = addr_reg;
    to_mem_next = to_mem_reg;
    wr_next = wr_reg;
    pa_next = pa_reg;
    flags_next = flags_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    mem_we = 1'b0;
    mem_wdata = 8'h00;
    case (state_reg)
      ST_IDLE: begin
        if (start_i && op_i != OP_NONE) begin
          op_next = op_i;
          imm_next = imm_i;
          addr_next = addr_i;
          to_mem_next = to_mem_i;
          busy_next = 1'b1;
          state_next = is_mem_read(op_i) ? ST_READ : ST_EXEC;
        end
      end
      ST_READ: begin
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        opnd = is_mem_read(op_reg) ? mem_rdata : imm_reg;
        case (op_reg)
          OP_AND_IMM, OP_AND_MEM: res = wr_reg & opnd; // [RQ1] [RQ2]
          OP_OR_IMM, OP_OR_MEM: res = wr_reg | opnd; // [RQ3] [RQ4]
          OP_XOR_IMM, OP_XOR_MEM: res = wr_reg ^ opnd; // [RQ5] [RQ6]
          OP_XOR_PORT, OP_XOR_TO_PT: res = wr_reg ^ pa_reg; // [RQ7] [RQ8]
          OP_NOT_WR: res = ~wr_reg; // [RQ9]
          OP_NOT_MEM: res = ~opnd; // [RQ10]
          OP_NEG_WR: res = 8'h00 - wr_reg; // [RQ11]
          OP_NEG_MEM: res = 8'h00 - opnd; // [RQ12]
          default: res = 8'h00;
        endcase
        case (op_reg)
          OP_CMP_IMM, OP_CMP_MEM: begin
            flags_next = sub_flags(wr_reg, opnd); // [RQ13] [RQ14] [RQ16]
          end
          OP_CMP_REV: begin
            flags_next = sub_flags(opnd, wr_reg); // [RQ15] [RQ16]
          end
          OP_XOR_TO_PT: begin
            pa_next = res; // [RQ8]
          end
          OP_NOT_MEM, OP_NEG_MEM: begin
            mem_we = 1'b1; // [RQ10] [RQ12]
            mem_wdata = res;
            flags_next[FLAG_ZERO_BIT] = (res == 8'h00); // [RQ17]
          end
          OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM: begin
            if (to_mem_reg) begin
              mem_we = 1'b1; // [RQ2] [RQ4] [RQ6]
              mem_wdata = res;
            end else begin
              wr_next = res;
            end
            flags_next[FLAG_ZERO_BIT] = (res == 8'h00); // [RQ17]
          end
          default: begin
            wr_next = res; // [RQ1] [RQ3] [RQ5] [RQ7] [RQ9] [RQ11]
            flags_next[FLAG_ZERO_BIT] = (res == 8'h00); // [RQ17]
          end
        endcase
        busy_next = 1'b0;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      imm_reg <= 8'h00;
      addr_reg <= 8'h00;
      to_mem_reg <= 1'b0;
      wr_reg <= WR_RESET;
      pa_reg <= PORT_A_RESET;
      flags_reg <= FLAGS_RESET;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      op_reg <= op_next;
      imm_reg <= imm_next;
      addr_reg <= addr_next;
      to_mem_reg <= to_mem_next;
      wr_reg <= wr_next;
      pa_reg <= pa_next;
      flags_reg <= flags_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign working_register_o = wr_reg;
  assign port_a_data_o = pa_reg;
  assign zero_flag_o = flags_reg[FLAG_ZERO_BIT];
  assign carry_flag_o = flags_reg[FLAG_CARRY_BIT];
  assign nibble_borrow_flag_o = flags_reg[FLAG_NIBBLE_BIT];
  assign signed_range_flag_o = flags_reg[FLAG_RANGE_BIT];

  // ***********************************************************
  // Checks
  // ***********************************************************
  logic in_exec;
  logic [7:0] opnd_view;
  assign in_exec = (state_reg == ST_EXEC) && clk_en_i;
  assign opnd_view = is_mem_read(op_reg) ? mem_rdata : imm_reg;

  sequence s_exec_logic_imm;
    in_exec && (op_reg inside {OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM});
  endsequence

  AST_IMM_FLAGS_KEPT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ1]
    s_exec_logic_imm |=> (flags_reg[3:1] == $past(flags_reg[3:1])))
    else $error("Logic immediate changed a flag other than zero.");

  AST_AND_IMM_RESULT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ1]
    in_exec && op_reg == OP_AND_IMM |=> wr_reg == ($past(wr_reg) & $past(imm_reg)))
    else $error("AND immediate result wrong.");

  AST_OR_IMM_RESULT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ3]
    in_exec && op_reg == OP_OR_IMM |=> wr_reg == ($past(wr_reg) | $past(imm_reg)))
    else $error("OR immediate result wrong.");

  AST_XOR_IMM_RESULT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ5]
    in_exec && op_reg == OP_XOR_IMM |=> wr_reg == ($past(wr_reg) ^ $past(imm_reg)))
    else $error("XOR immediate result wrong.");

  AST_MEM_DEST_WRITE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ2] [RQ4] [RQ6]
    in_exec && (op_reg inside {OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM}) && to_mem_reg
    |-> mem_we ##1 $stable(wr_reg))
    else $error("Memory destination did not write memory or disturbed the register.");

  AST_XOR_PORT_RESULT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ7]
    in_exec && op_reg == OP_XOR_PORT |=> wr_reg == ($past(wr_reg) ^ pa_reg))
    else $error("XOR with port result wrong.");

  AST_XOR_TO_PORT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ8]
    in_exec && op_reg == OP_XOR_TO_PT |=> flags_reg == $past(flags_reg)
      && pa_reg == ($past(wr_reg) ^ $past(pa_reg)) && $stable(wr_reg))
    else $error("XOR into port changed flags or wrote wrong value.");

  AST_NOT_WR: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ9] [RQ17]
    in_exec && op_reg == OP_NOT_WR |=> wr_reg == ~$past(wr_reg)
      && zero_flag_o == (wr_reg == 8'h00))
    else $error("Inversion of working register wrong.");

  AST_NEG_WR: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ11]
    in_exec && op_reg == OP_NEG_WR |=> wr_reg == (8'h00 - $past(wr_reg))
      && flags_reg[3:1] == $past(flags_reg[3:1]))
    else $error("Negation of working register wrong.");

  AST_MEM_INPLACE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ10] [RQ12]
    in_exec && (op_reg inside {OP_NOT_MEM, OP_NEG_MEM}) |-> mem_we
      && (mem_wdata == (op_reg == OP_NOT_MEM ? ~mem_rdata : 8'h00 - mem_rdata)))
    else $error("In-place memory update wrong.");

  sequence s_cmp_start;
    start_i && state_reg == ST_IDLE && clk_en_i
      && (op_i inside {OP_CMP_IMM, OP_CMP_MEM, OP_CMP_REV});
  endsequence

  // An immediate compare executes one cycle after it is taken, a memory compare two.
  sequence s_cmp_exec;
    s_cmp_start ##[1:2] in_exec;
  endsequence

  AST_CMP_NO_STORE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ13]
    s_cmp_exec |-> !mem_we ##1 $stable(wr_reg))
    else $error("Compare stored a result.");

  AST_CMP_FLAGS: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ14] [RQ16]
    in_exec && (op_reg inside {OP_CMP_IMM, OP_CMP_MEM}) |=>
      carry_flag_o == ($past(wr_reg) < $past(opnd_view))
      && zero_flag_o == ($past(wr_reg) == $past(opnd_view)))
    else $error("Compare flags wrong.");

  AST_CMP_NIBBLE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ13]
    in_exec && (op_reg inside {OP_CMP_IMM, OP_CMP_MEM}) |=>
      nibble_borrow_flag_o == ($past(wr_reg[3:0]) < $past(opnd_view[3:0])))
    else $error("Compare nibble borrow wrong.");

  AST_CMP_REV_FLAGS: assert property (@(posedge ref_clk_i) disable iff (srst_i) // [RQ15] [RQ16]
    in_exec && op_reg == OP_CMP_REV |=>
      carry_flag_o == ($past(mem_rdata) < $past(wr_reg)))
    else $error("Reversed compare carry wrong.");

endmodule

`default_nettype wire

// ===== logic_compare_pkg.sv
package logic_compare_pkg;

  // ***********************************************************
  // Operation codes
  // ***********************************************************
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_AND_IMM   = 4'h1,
    OP_AND_MEM   = 4'h2,
    OP_OR_IMM    = 4'h3,
    OP_OR_MEM    = 4'h4,
    OP_XOR_IMM   = 4'h5,
    OP_XOR_MEM   = 4'h6,
    OP_XOR_PORT  = 4'h7,
    OP_XOR_TO_PT = 4'h8,
    OP_NOT_WR    = 4'h9,
    OP_NOT_MEM   = 4'ha,
    OP_NEG_WR    = 4'hb,
    OP_NEG_MEM   = 4'hc,
    OP_CMP_IMM   = 4'hd,
    OP_CMP_MEM   = 4'he,
    OP_CMP_REV   = 4'hf
  } op_t;

  // ***********************************************************
  // Widths, reset values and flag positions
  // ***********************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam logic [7:0] WR_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int FLAG_ZERO_BIT = 0;
  localparam int FLAG_CARRY_BIT = 1;
  localparam int FLAG_NIBBLE_BIT = 2;
  localparam int FLAG_RANGE_BIT = 3;
  localparam logic [7:0] PORT_A_RESET = 8'h00;

  // ***********************************************************
  // Operation sequencing
  // ***********************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_EXEC  = 2'b10
  } state_t;

endpackage

// ===== data_mem.sv
`timescale 1ns/1ps
`default_nettype none

module data_mem (
  // Clock and enable.
  input wire logic ref_clk_i,
  input wire logic clk_en_i,
  // Write port.
  input wire logic wr_en_i,
  input wire logic [logic_compare_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [logic_compare_pkg::DATA_W-1:0] wr_data_i,
  // Read port.
  input wire logic [logic_compare_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [logic_compare_pkg::DATA_W-1:0] rd_data_o
);
  import logic_compare_pkg::*;

  logic [DATA_W-1:0] mem_reg [MEM_DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      if (wr_en_i) begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule

`default_nettype wire

// ===== data_store_model.sv
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************
// Byte store seen by the unit
// ***********************************************************
// Cells start unknown, as the real store has no reset.
module data_store_model;
  import logic_compare_pkg::*;
  logic [DATA_W-1:0] cells [MEM_DEPTH];
endmodule

`default_nettype wire

// ===== logic_compare_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module logic_compare_unit_tb;
  import logic_compare_pkg::*;

  // Each row: operation, register, operand, destination, then result and flags expected.
  typedef struct {
    op_t o;
    logic [7:0] w;
    logic [7:0] v;
    logic t;
    logic [7:0] e;
    logic [3:0] f;
  } row_t;

  logic ref_clk_i, srst, clk_en, start, to_mem, busy, done, zf, cf, nf, rf;
  op_t op;
  logic [7:0] imm, addr, wreg, preg, wr_m, pa_m, pat;
  logic [3:0] flags_m;
  logic [7:0] ra, res_m;
  row_t rw;
  int checks = 0;
  int num_errors = 0;
  row_t rows [22] = '{
    '{OP_AND_IMM, 8'h3c, 8'h0f, 1'b0, 8'h0c, 4'he},
    '{OP_AND_IMM, 8'hf0, 8'h0f, 1'b0, 8'h00, 4'hf},
    '{OP_AND_MEM, 8'h5a, 8'h3c, 1'b0, 8'h18, 4'he},
    '{OP_AND_MEM, 8'h5a, 8'ha5, 1'b1, 8'h00, 4'hf},
    '{OP_OR_IMM, 8'h00, 8'h00, 1'b0, 8'h00, 4'hf},
    '{OP_OR_IMM, 8'h30, 8'h0f, 1'b0, 8'h3f, 4'he},
    '{OP_OR_MEM, 8'h81, 8'h18, 1'b0, 8'h99, 4'he},
    '{OP_OR_MEM, 8'h00, 8'h00, 1'b1, 8'h00, 4'hf},
    '{OP_XOR_IMM, 8'h0f, 8'h0f, 1'b0, 8'h00, 4'hf},
    '{OP_XOR_MEM, 8'h3c, 8'hff, 1'b0, 8'hc3, 4'he},
    '{OP_XOR_MEM, 8'h3c, 8'h3c, 1'b1, 8'h00, 4'hf},
    '{OP_XOR_PORT, 8'h55, 8'h55, 1'b0, 8'h00, 4'hf},
    '{OP_XOR_TO_PT, 8'h5a, 8'h5a, 1'b0, 8'h00, 4'he},
    '{OP_NOT_WR, 8'h38, 8'h00, 1'b0, 8'hc7, 4'he},
    '{OP_NOT_MEM, 8'h00, 8'hff, 1'b0, 8'h00, 4'hf},
    '{OP_NEG_WR, 8'h38, 8'h00, 1'b0, 8'hc8, 4'he},
    '{OP_NEG_MEM, 8'h00, 8'h80, 1'b0, 8'h80, 4'he},
    '{OP_CMP_IMM, 8'h38, 8'h38, 1'b0, 8'h00, 4'h1},
    '{OP_CMP_IMM, 8'h38, 8'h6a, 1'b0, 8'hce, 4'h6},
    '{OP_CMP_IMM, 8'h80, 8'h01, 1'b0, 8'h7f, 4'hc},
    '{OP_CMP_MEM, 8'h38, 8'h24, 1'b0, 8'h14, 4'h0},
    '{OP_CMP_REV, 8'h38, 8'h24, 1'b0, 8'hec, 4'h6}
  };

  logic_compare_unit dut_u (
    .ref_clk_i(ref_clk_i), .srst_i(srst), .clk_en_i(clk_en), .start_i(start), .op_i(op),
    .imm_i(imm), .addr_i(addr), .to_mem_i(to_mem), .busy_o(busy), .done_o(done),
    .working_register_o(wreg), .port_a_data_o(preg), .zero_flag_o(zf), .carry_flag_o(cf),
    .nibble_borrow_flag_o(nf), .signed_range_flag_o(rf)
  );
  data_store_model mem_m ();

  // ***********************************************************
  // Checking and reference
  // ***********************************************************
  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flags(input string name, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_state();
    chk_byte("working_register", wr_m, wreg);
    chk_byte("port_a_data", pa_m, preg);
    chk_flags("flags", flags_m, {rf, nf, cf, zf});
  endtask

  function automatic logic is_mem(input op_t o);
    return o inside {OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM, OP_NOT_MEM, OP_NEG_MEM, OP_CMP_MEM,
                     OP_CMP_REV};
  endfunction

  task automatic model_step(input op_t o, input logic [7:0] i, a, input logic t);
    logic [7:0] m, r, x, y, d;
    m = mem_m.cells[a];
    x = (o == OP_CMP_REV) ? m : wr_m;
    y = (o == OP_CMP_IMM) ? i : ((o == OP_CMP_REV) ? wr_m : m);
    d = x - y;
    case (o)
      OP_AND_IMM: r = wr_m & i;
      OP_AND_MEM: r = wr_m & m;
      OP_OR_IMM: r = wr_m | i;
      OP_OR_MEM: r = wr_m | m;
      OP_XOR_IMM: r = wr_m ^ i;
      OP_XOR_MEM: r = wr_m ^ m;
      OP_XOR_PORT, OP_XOR_TO_PT: r = wr_m ^ pa_m;
      OP_NOT_WR: r = ~wr_m;
      OP_NOT_MEM: r = ~m;
      OP_NEG_WR: r = 8'h00 - wr_m;
      OP_NEG_MEM: r = 8'h00 - m;
      default: begin
        r = d;
        flags_m[FLAG_CARRY_BIT] = x < y;
        flags_m[FLAG_NIBBLE_BIT] = x[3:0] < y[3:0];
        flags_m[FLAG_RANGE_BIT] = (x[7] ^ y[7]) & (d[7] ^ x[7]);
      end
    endcase
    case (o)
      OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM: if (t) mem_m.cells[a] = r; else wr_m = r;
      OP_NOT_MEM, OP_NEG_MEM: mem_m.cells[a] = r;
      OP_XOR_TO_PT: pa_m = r;
      OP_CMP_IMM, OP_CMP_MEM, OP_CMP_REV: begin end
      default: wr_m = r;
    endcase
    if (o != OP_XOR_TO_PT) flags_m[FLAG_ZERO_BIT] = (r == 8'h00);
    res_m = r;
  endtask

  // ***********************************************************
  // Drivers
  // ***********************************************************
  // Each driver is entered and left at a rising edge.
  task automatic run_op(input op_t o, input logic [7:0] i, a, input logic t);
    int n;
    n = 0;
    start <= 1'b1;
    op <= o;
    imm <= i;
    addr <= a;
    to_mem <= t;
    @(posedge ref_clk_i);
    start <= 1'b0;
    model_step(o, i, a, t);
    do begin
      @(negedge ref_clk_i);
      n++;
      if (n == 1) chk_byte("busy", 8'h01, {7'h00, busy});
    end while (done !== 1'b1 && n < 8);
    chk_byte("latency", is_mem(o) ? 8'h03 : 8'h02, 8'(n));
    chk_state();
    @(posedge ref_clk_i);
  endtask

  task automatic load_wr(input logic [7:0] v);
    run_op(OP_AND_IMM, 8'h00, 8'h00, 1'b0);
    run_op(OP_OR_IMM, v, 8'h00, 1'b0);
  endtask

  task automatic watch_idle(input string name);
    pat = 8'h00;
    repeat (4) begin
      @(negedge ref_clk_i);
      pat = pat | {7'h00, done | busy};
    end
    chk_byte(name, 8'h00, pat);
    chk_state();
    @(posedge ref_clk_i);
  endtask

  task automatic do_reset();
    @(posedge ref_clk_i);
    srst <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    srst <= 1'b0;
    wr_m = 8'h00;
    pa_m = 8'h00;
    flags_m = 4'h0;
    @(negedge ref_clk_i);
    chk_state();
    chk_byte("status", 8'h00, {6'h00, busy, done});
    @(posedge ref_clk_i);
  endtask

  // ***********************************************************
  // Sequence
  // ***********************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    start = 1'b0;
    op = OP_NONE;
    imm = 8'h00;
    addr = 8'h00;
    to_mem = 1'b0;
    do_reset();
    foreach (rows[k]) begin
      rw = rows[k];
      ra = 8'h10 + 8'(k);
      if (is_mem(rw.o)) begin
        load_wr(8'h00);
        run_op(OP_AND_MEM, 8'h00, ra, 1'b1);
        load_wr(rw.v);
        run_op(OP_OR_MEM, 8'h00, ra, 1'b1);
      end
      if (rw.o inside {OP_XOR_PORT, OP_XOR_TO_PT}) begin
        load_wr(pa_m ^ rw.v);
        run_op(OP_XOR_TO_PT, 8'h00, 8'h00, 1'b0);
      end
      load_wr(8'h70);
      run_op(OP_CMP_IMM, 8'h81, 8'h00, 1'b0);
      load_wr(rw.w);
      run_op(rw.o, rw.v, ra, rw.t);
      chk_byte("row_result", rw.e, res_m);
      chk_flags("row_flags", rw.f, flags_m);
      if (is_mem(rw.o)) begin
        load_wr(8'h00);
        run_op(OP_XOR_MEM, 8'h00, ra, 1'b0);
      end
    end
    // Start held through busy and done: second take only in the done cycle.
    load_wr(8'h5a);
    start <= 1'b1;
    op <= OP_XOR_IMM;
    imm <= 8'hff;
    to_mem <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk_i);
      pat[i] = done;
      @(posedge ref_clk_i);
      if (i == 2) start <= 1'b0;
    end
    pat[7:5] = 3'b000;
    model_step(OP_XOR_IMM, 8'hff, 8'h00, 1'b0);
    model_step(OP_XOR_IMM, 8'hff, 8'h00, 1'b0);
    chk_byte("done_pattern", 8'h14, pat);
    start <= 1'b1;
    op <= OP_NONE;
    @(posedge ref_clk_i);
    start <= 1'b0;
    watch_idle("idle_for_none");
    clk_en <= 1'b0;
    start <= 1'b1;
    op <= OP_XOR_IMM;
    repeat (3) @(posedge ref_clk_i);
    clk_en <= 1'b1;
    start <= 1'b0;
    watch_idle("idle_when_frozen");
    load_wr(8'hc3);
    do_reset();
    test_done();
  end
endmodule

`default_nettype wire
